// file: rtl/ccf_pkg.sv
/*
 * Package for the condition-code flag block: bit positions, reset value,
 * operation and size codes shared by the flag unit and its evaluator.
 * Assumes a single core clock and an instruction decoder outside this block.
 */
package ccf_pkg;
    localparam int CCF_BIT_MASK = 7;
    localparam int CCF_BIT_SPARE6 = 6;
    localparam int CCF_BIT_HALF = 5;
    localparam int CCF_BIT_SPARE4 = 4;
    localparam int CCF_BIT_NEG = 3;
    localparam int CCF_BIT_ZERO = 2;
    localparam int CCF_BIT_OVF = 1;
    localparam int CCF_BIT_CARRY = 0;
    localparam logic CCF_MASK_RESET = 1'b1;
    // Half-carry tap positions per operand size
    localparam int CCF_HC_BYTE = 3;
    localparam int CCF_HC_WORD = 11;
    localparam int CCF_HC_LONG = 27;

    typedef enum logic [1:0] {
        CCF_SZ_BYTE = 2'b00,
        CCF_SZ_WORD = 2'b01,
        CCF_SZ_LONG = 2'b10
    } ccf_size_t;

    typedef enum logic [3:0] {
        CCF_OP_NONE = 4'h0,
        CCF_OP_ADD = 4'h1,
        CCF_OP_PLUS_WITH_EXTEND_INSTR = 4'h2,
        CCF_OP_SUB = 4'h3,
        CCF_OP_MINUS_WITH_EXTEND_INSTR = 4'h4,
        CCF_OP_CMP = 4'h5,
        CCF_OP_NEG = 4'h6,
        CCF_OP_LOGIC = 4'h7,
        CCF_OP_SHIFT = 4'h8,
        CCF_OP_BITACC = 4'h9
    } ccf_op_t;

    typedef enum logic [2:0] {
        CCF_CTL_NONE = 3'h0,
        CCF_CTL_LOAD = 3'h1,
        CCF_CTL_AND = 3'h2,
        CCF_CTL_OR = 3'h3,
        CCF_CTL_XOR = 3'h4
    } ccf_ctl_t;

    typedef enum logic [3:0] {
        CCF_CC_T = 4'h0, CCF_CC_F = 4'h1, CCF_CC_HI = 4'h2, CCF_CC_LS = 4'h3,
        CCF_CC_CC = 4'h4, CCF_CC_CS = 4'h5, CCF_CC_NE = 4'h6, CCF_CC_EQ = 4'h7,
        CCF_CC_VC = 4'h8, CCF_CC_VS = 4'h9, CCF_CC_PL = 4'ha, CCF_CC_MI = 4'hb,
        CCF_CC_GE = 4'hc, CCF_CC_LT = 4'hd, CCF_CC_GT = 4'he, CCF_CC_LE = 4'hf
    } ccf_cond_t;
endpackage

// file: rtl/ccf_branch_eval.sv
/*
 * Branch condition evaluator: combines N, Z, V and C into a taken bit.
 * Assumes flag inputs come straight from the condition-code register.
 */
`timescale 1ns/1ns
module ccf_branch_eval
    import ccf_pkg::*;
(
    input wire ccf_pkg::ccf_cond_t cond, // Branch condition code
    input wire logic flag_n, // Negative flag
    input wire logic flag_z, // Zero flag
    input wire logic flag_v, // Overflow flag
    input wire logic flag_c, // Carry flag
    output logic taken // Condition holds
);
    always_comb begin
        unique case (cond)
            CCF_CC_T: taken = 1'b1;
            CCF_CC_F: taken = 1'b0;
            CCF_CC_HI: taken = !(flag_c | flag_z);
            CCF_CC_LS: taken = flag_c | flag_z;
            CCF_CC_CC: taken = !flag_c;
            CCF_CC_CS: taken = flag_c;
            CCF_CC_NE: taken = !flag_z;
            CCF_CC_EQ: taken = flag_z;
            CCF_CC_VC: taken = !flag_v;
            CCF_CC_VS: taken = flag_v;
            CCF_CC_PL: taken = !flag_n;
            CCF_CC_MI: taken = flag_n;
            CCF_CC_GE: taken = !(flag_n ^ flag_v);
            CCF_CC_LT: taken = flag_n ^ flag_v;
            CCF_CC_GT: taken = !(flag_z | (flag_n ^ flag_v));
            CCF_CC_LE: taken = flag_z | (flag_n ^ flag_v);
        endcase
    end
endmodule // ccf_branch_eval

// file: rtl/ccf_flags.sv
/*
 * Condition-code register with flag-update logic, interrupt acceptance
 * and branch evaluation. Assumes the datapath hands over both operands,
 * the operation and size with op_valid; flags update at that edge.
 * Only one of ctl_op / op_valid / exc_start is expected per cycle;
 * exception start only forces the mask bit, and a control op wins over op_valid.
 */
`timescale 1ns/1ns
// Behaviour
// - Mask bit set blocks maskable interrupts, not NMI
// - Exception start forces mask bit to one
// - Reset sets mask bit only, others undefined
// - Bits six and four are plain storage
// - Bit six never masks interrupts
// - Load, store, AND, OR, XOR control register
// - Branches test N, Z, V, C
// - Byte arithmetic half-carry from bit three
// - Word arithmetic half-carry from bit eleven
// - Longword arithmetic half-carry from bit 27
// - Negative flag is result sign bit
// - Zero flag set for all-zero result; extend ops only keep it set
// - Overflow flag set on signed overflow
// - Carry from add, borrow, shifted-out bit
// - Carry flag is bit-manipulation accumulator
module ccf_flags
    import ccf_pkg::*;
#(
    parameter int DATA_W = 32 // Datapath width
) (
    input wire logic core_clk, // Core clock, 250 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire ccf_pkg::ccf_ctl_t ctl_op, // Control-register instruction
    input wire logic [7:0] ctl_data, // Load value or immediate
    output logic [7:0] ctl_rdata, // Stored register value
    input wire logic op_valid, // Datapath operation completes
    input wire ccf_pkg::ccf_op_t op_kind, // Operation class
    input wire ccf_pkg::ccf_size_t op_size, // Operand size
    input wire logic [DATA_W-1:0] op_a, // Destination operand
    input wire logic [DATA_W-1:0] op_b, // Source operand
    input wire logic [DATA_W-1:0] op_res, // Result from datapath
    input wire logic shift_out, // Bit shifted or rotated out
    input wire logic shift_ovf, // Overflow from arithmetic shift
    input wire logic bit_res, // Bit-manipulation accumulator result
    input wire logic bit_wr_c, // Bit op writes carry
    input wire logic exc_start, // Exception handling begins
    input wire logic irq_req, // Maskable interrupt request
    input wire logic nmi_req, // Non-maskable interrupt request
    output logic irq_accept, // Maskable request accepted
    output logic nmi_accept, // Non-maskable request accepted
    input wire ccf_pkg::ccf_cond_t br_cond, // Branch condition
    output logic br_taken, // Branch condition holds
    output logic carry_acc // Carry as bit accumulator operand
);
    import ccf_pkg::*;

    initial begin
        if (DATA_W != 32) $error("ccf_flags: DATA_W must be 32");
    end

    logic [7:0] ccr_r;
    logic [7:0] ccr_nxt;
    logic mask_r;
    logic mask_nxt;

    function automatic int size_msb(ccf_size_t s);
        unique case (s)
            CCF_SZ_BYTE: return 7;
            CCF_SZ_WORD: return 15;
            default: return 31;
        endcase
    endfunction

    function automatic int size_hc(ccf_size_t s);
        unique case (s)
            CCF_SZ_BYTE: return CCF_HC_BYTE;
            CCF_SZ_WORD: return CCF_HC_WORD;
            default: return CCF_HC_LONG;
        endcase
    endfunction

    logic [DATA_W-1:0] szmask;
    logic [DATA_W-1:0] res_m;
    logic [DATA_W-1:0] cvec;
    logic is_add;
    logic is_sub;
    logic is_arith;
    logic sa;
    logic sb;
    logic sr;
    int msb;

    always_comb begin
        msb = size_msb(op_size);
        szmask = (op_size == CCF_SZ_BYTE) ? 32'h0000_00ff :
                 (op_size == CCF_SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
        res_m = op_res & szmask;
        is_add = (op_kind == CCF_OP_ADD) || (op_kind == CCF_OP_PLUS_WITH_EXTEND_INSTR);
        is_sub = (op_kind == CCF_OP_SUB) || (op_kind == CCF_OP_MINUS_WITH_EXTEND_INSTR)
              || (op_kind == CCF_OP_CMP) || (op_kind == CCF_OP_NEG);
        is_arith = is_add || is_sub;
        // Carry into each bit; for subtraction this recovers the borrow chain
        cvec = is_add ? (op_a ^ op_b ^ op_res) : (op_a ^ op_b ^ op_res);
        sa = op_a[msb];
        sb = op_b[msb];
        sr = op_res[msb];
    end

    logic carry_top;
    logic half_c;
    logic ovf;

    always_comb begin
        // Carry/borrow out of the top bit at the operand size
        carry_top = is_add ? ((sa & sb) | ((sa | sb) & !sr))
                           : ((!sa & sb) | ((!sa | sb) & sr));
        half_c = cvec[size_hc(op_size) + 1];
        ovf = is_add ? ((sa == sb) && (sr != sa))
                     : ((sa != sb) && (sr != sa));
    end

    // Bit 7 of ccr_r is not reset, so the live mask flop stands in for it
    logic [7:0] ccr_cur;

    always_comb begin
        ccr_cur = {mask_r, ccr_r[6:0]};
        ccr_nxt = ccr_cur;
        unique case (ctl_op)
            CCF_CTL_LOAD: ccr_nxt = ctl_data;
            CCF_CTL_AND: ccr_nxt = ccr_cur & ctl_data;
            CCF_CTL_OR: ccr_nxt = ccr_cur | ctl_data;
            CCF_CTL_XOR: ccr_nxt = ccr_cur ^ ctl_data;
            default: ccr_nxt = ccr_cur;
        endcase
        if (ctl_op == CCF_CTL_NONE && op_valid) begin
            if (is_arith) begin
                ccr_nxt[CCF_BIT_HALF] = half_c;
                ccr_nxt[CCF_BIT_NEG] = sr;
                ccr_nxt[CCF_BIT_ZERO] = (res_m == '0) && (op_kind != CCF_OP_PLUS_WITH_EXTEND_INSTR
                    && op_kind != CCF_OP_MINUS_WITH_EXTEND_INSTR || ccr_r[CCF_BIT_ZERO]);
                ccr_nxt[CCF_BIT_OVF] = ovf;
                ccr_nxt[CCF_BIT_CARRY] = carry_top;
            end else if (op_kind == CCF_OP_LOGIC) begin
                ccr_nxt[CCF_BIT_NEG] = sr;
                ccr_nxt[CCF_BIT_ZERO] = (res_m == '0);
                ccr_nxt[CCF_BIT_OVF] = 1'b0;
            end else if (op_kind == CCF_OP_SHIFT) begin
                ccr_nxt[CCF_BIT_NEG] = sr;
                ccr_nxt[CCF_BIT_ZERO] = (res_m == '0);
                ccr_nxt[CCF_BIT_OVF] = shift_ovf;
                ccr_nxt[CCF_BIT_CARRY] = shift_out;
            end else if (op_kind == CCF_OP_BITACC && bit_wr_c) begin
                ccr_nxt[CCF_BIT_CARRY] = bit_res;
            end
        end
        mask_nxt = ccr_nxt[CCF_BIT_MASK];
        if (exc_start) begin
            mask_nxt = 1'b1;
        end
    end

    // Only the mask bit is reset; the rest stay undefined by design
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mask_r <= CCF_MASK_RESET;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        ccr_r <= {mask_nxt, ccr_nxt[6:0]};
    end

    always_comb begin
        ctl_rdata = {mask_r, ccr_r[6:0]};
        // Bit six is deliberately not looked at here
        irq_accept = irq_req && !mask_r;
        nmi_accept = nmi_req;
        carry_acc = ccr_r[CCF_BIT_CARRY];
    end

    ccf_branch_eval u_eval (
        .cond(br_cond),
        .flag_n(ccr_r[CCF_BIT_NEG]),
        .flag_z(ccr_r[CCF_BIT_ZERO]),
        .flag_v(ccr_r[CCF_BIT_OVF]),
        .flag_c(ccr_r[CCF_BIT_CARRY]),
        .taken(br_taken)
    );

    mask_block_a: assert property (@(posedge core_clk) disable iff (reset)
        mask_r |-> !irq_accept) else $error("irq accepted while masked");
    nmi_pass_a: assert property (@(posedge core_clk) disable iff (reset)
        nmi_req |-> nmi_accept) else $error("nmi refused");
    exc_mask_a: assert property (@(posedge core_clk) disable iff (reset)
        exc_start |=> mask_r) else $error("mask not set on exception");
    load_all_a: assert property (@(posedge core_clk) disable iff (reset)
        (ctl_op == CCF_CTL_LOAD && !exc_start) |=> ctl_rdata == $past(ctl_data))
        else $error("control load lost");
    zero_flag_a: assert property (@(posedge core_clk) disable iff (reset)
        (op_valid && ctl_op == CCF_CTL_NONE && op_kind == CCF_OP_LOGIC)
        |=> ccr_r[CCF_BIT_ZERO] == ($past(res_m) == '0)) else $error("zero flag wrong");
    neg_flag_a: assert property (@(posedge core_clk) disable iff (reset)
        (op_valid && ctl_op == CCF_CTL_NONE && op_kind == CCF_OP_LOGIC)
        |=> ccr_r[CCF_BIT_NEG] == $past(sr)) else $error("negative flag wrong");
    keep_flags_a: assert property (@(posedge core_clk) disable iff (reset)
        (!op_valid && ctl_op == CCF_CTL_NONE) |=> $stable(ccr_r[6:0]))
        else $error("flags changed without cause");
    spare_keep_a: assert property (@(posedge core_clk) disable iff (reset)
        (op_valid && ctl_op == CCF_CTL_NONE) |=> $stable(ccr_r[CCF_BIT_SPARE6])
        && $stable(ccr_r[CCF_BIT_SPARE4])) else $error("user bits disturbed");
    bit_carry_a: assert property (@(posedge core_clk) disable iff (reset)
        (op_valid && ctl_op == CCF_CTL_NONE && op_kind == CCF_OP_BITACC && bit_wr_c)
        |=> carry_acc == $past(bit_res)) else $error("accumulator not written");
endmodule // ccf_flags

// file: test/ccf_flags_test.sv
/*
 * Self-checking bench for ccf_flags: control-register ops, flag updates,
 * branch conditions and interrupt acceptance against a flag model.
 * Assumes the ccf_pkg encodings and a one-cycle register update.
 */
`timescale 1ns/1ns
module ccf_flags_test;
    import ccf_pkg::*;
    typedef struct packed {logic [7:0] val; logic [7:0] known;} ccf_note_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    ccf_ctl_t ctl_op = CCF_CTL_NONE;
    ccf_op_t op_kind = CCF_OP_NONE;
    ccf_size_t op_size = CCF_SZ_BYTE;
    ccf_cond_t br_cond = CCF_CC_T;
    logic [7:0] ctl_data = 8'h00;
    logic [7:0] ctl_rdata;
    logic [31:0] op_a = 32'h0, op_b = 32'h0, op_res = 32'h0, mk;
    logic [32:0] s;
    logic op_valid = 1'b0, shift_out = 1'b0, shift_ovf = 1'b0, bit_res = 1'b0;
    logic bit_wr_c = 1'b0, exc_start = 1'b0, irq_req = 1'b1, nmi_req = 1'b1, pend = 1'b0;
    logic irq_accept, nmi_accept, br_taken, carry_acc;
    // Flags not yet written are unknown, so only known bits are compared
    logic [7:0] m = 8'h80, k = 8'h80, ev;
    int failures = 0, total_checks = 0, seed = 32'h3a02e88a;
    ccf_note_t notes[$], n;

    ccf_flags #(.DATA_W(32)) uut (.core_clk(core_clk), .reset(reset), .ctl_op(ctl_op),
        .ctl_data(ctl_data), .ctl_rdata(ctl_rdata), .op_valid(op_valid), .op_kind(op_kind),
        .op_size(op_size), .op_a(op_a), .op_b(op_b), .op_res(op_res), .shift_out(shift_out),
        .shift_ovf(shift_ovf), .bit_res(bit_res), .bit_wr_c(bit_wr_c), .exc_start(exc_start),
        .irq_req(irq_req), .nmi_req(nmi_req), .irq_accept(irq_accept),
        .nmi_accept(nmi_accept), .br_cond(br_cond), .br_taken(br_taken), .carry_acc(carry_acc));

    always #2 core_clk = ~core_clk;

    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic int width_of(ccf_size_t sz);
        return (sz == CCF_SZ_BYTE) ? 8 : (sz == CCF_SZ_WORD) ? 16 : 32;
    endfunction

    // Sum or difference over the low bits, carry or borrow lands in bit [bits]
    function automatic logic [32:0] fsum(int bits);
        logic [31:0] bm;
        logic ci;
        bm = 32'hffffffff >> (32 - bits);
        ci = (op_kind inside {CCF_OP_PLUS_WITH_EXTEND_INSTR, CCF_OP_MINUS_WITH_EXTEND_INSTR}) & m[0];
        return (op_kind inside {CCF_OP_SUB, CCF_OP_MINUS_WITH_EXTEND_INSTR, CCF_OP_CMP, CCF_OP_NEG}) ?
            {1'b0, op_a & bm} - {1'b0, op_b & bm} - ci : {1'b0, op_a & bm} + {1'b0, op_b & bm} + ci;
    endfunction

    task automatic upd();
        int w;
        int hc;
        logic [32:0] f;
        logic [32:0] h;
        logic [31:0] r;
        logic sb;
        w = width_of(op_size);
        hc = (w == 8) ? CCF_HC_BYTE : (w == 16) ? CCF_HC_WORD : CCF_HC_LONG;
        f = fsum(w);
        h = fsum(hc + 1);
        r = op_res & (32'hffffffff >> (32 - w));
        sb = op_kind inside {CCF_OP_SUB, CCF_OP_MINUS_WITH_EXTEND_INSTR, CCF_OP_CMP, CCF_OP_NEG};
        if (op_kind <= CCF_OP_SHIFT) begin
            m[3] = r[w-1];
            m[2] = (r == 32'h0) & ((op_kind inside {CCF_OP_PLUS_WITH_EXTEND_INSTR, CCF_OP_MINUS_WITH_EXTEND_INSTR}) ? m[2] : 1'b1);
        end
        if (op_kind <= CCF_OP_NEG) begin
            m[5] = h[hc+1];
            m[1] = (op_a[w-1] ^ op_b[w-1] ^ !sb) & (r[w-1] ^ op_a[w-1]);
            m[0] = f[w];
        end
        if (op_kind == CCF_OP_LOGIC) m[1] = 1'b0;
        if (op_kind == CCF_OP_SHIFT) {m[1], m[0]} = {shift_ovf, shift_out};
        if (op_kind == CCF_OP_BITACC && bit_wr_c) m[0] = bit_res;
    endtask

    // Notes the expected register for the request now on the inputs, then lets it be taken
    task automatic go();
        if (exc_start) m[7] = 1'b1;
        else if (ctl_op == CCF_CTL_LOAD) {m, k} = {ctl_data, 8'hff};
        else if (ctl_op == CCF_CTL_AND) m = m & ctl_data;
        else if (ctl_op == CCF_CTL_OR) m = m | ctl_data;
        else if (ctl_op == CCF_CTL_XOR) m = m ^ ctl_data;
        else if (op_valid) upd();
        pend = exc_start | op_valid | (ctl_op != CCF_CTL_NONE);
        if (pend) notes.push_back({m, k});
        @(posedge core_clk);
        #1;
    endtask

    always @(posedge core_clk) begin
        if (pend) begin
            #2;
            n = notes.pop_front();
            chk("ccr", ctl_rdata & n.known, n.val & n.known);
        end
    end

    initial begin
        #200000;
        failures++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        chk("irq_rst", irq_accept, 1'b0);
        repeat (12) @(posedge core_clk);
        #1;
        reset = 1'b0;
        chk("mask_rst", ctl_rdata[7], 1'b1);
        chk("nmi_rst", nmi_accept, 1'b1);
        ctl_op = CCF_CTL_LOAD;
        go();
        ctl_op = CCF_CTL_NONE;
        exc_start = 1'b1;
        chk("irq_open", irq_accept, 1'b1);
        go();
        exc_start = 1'b0;
        go();
        chk("irq_exc", irq_accept, 1'b0);
        for (int i = 0; i < 120; i++) begin
            op_kind = ccf_op_t'(1 + {$random(seed)} % 9);
            op_size = (op_kind inside {CCF_OP_PLUS_WITH_EXTEND_INSTR, CCF_OP_MINUS_WITH_EXTEND_INSTR}) ? CCF_SZ_BYTE :
                ccf_size_t'({$random(seed)} % 3);
            op_a = (op_kind == CCF_OP_NEG) ? 32'h0 : $random(seed);
            op_b = ({$random(seed)} % 4 == 0) ? op_a : $random(seed);
            mk = 32'hffffffff >> (32 - width_of(op_size));
            s = fsum(width_of(op_size));
            op_res = (op_kind >= CCF_OP_LOGIC) ? $random(seed) : (op_a & ~mk) | (s[31:0] & mk);
            {shift_out, shift_ovf, bit_res, bit_wr_c} = 4'($random(seed));
            op_valid = 1'b1;
            // Every eighth cycle a control write meets the operation and must win
            ctl_op = (i % 8 == 7) ? CCF_CTL_XOR : CCF_CTL_NONE;
            ctl_data = 8'($random(seed));
            go();
        end
        op_valid = 1'b0;
        for (int i = 0; i < 16; i++) begin
            ctl_op = ccf_ctl_t'(1 + i % 4);
            ctl_data = 8'($random(seed));
            {irq_req, nmi_req} = 2'($random(seed));
            go();
            ctl_op = CCF_CTL_NONE;
            ev = {~(m[2] | (m[3] ^ m[1])), ~(m[3] ^ m[1]), ~m[3], ~m[1], ~m[2], ~m[0],
                ~(m[0] | m[2]), 1'b1};
            for (int c = 0; c < 16; c++) begin
                br_cond = ccf_cond_t'(c);
                go();
                chk("taken", br_taken, ev[c / 2] ^ c[0]);
            end
            chk("acc", carry_acc, m[0]);
            chk("irq", irq_accept, irq_req & ~m[7]);
            chk("nmi", nmi_accept, nmi_req);
        end
        summarize();
    end
endmodule // ccf_flags_test
